// ===== core/tdcl_pkg.sv
package tdcl_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int DUR_W     = 32;
  localparam int IDLE_W    = 40;
  localparam int DATA_W    = 8;
  localparam int FIFO_AW   = 3;
  localparam int FIFO_DEPTH = 8;

  // ==========================================================================
  // Duty-cycle figures, in percent
  // ==========================================================================
  localparam logic [7:0] PCT_FULL   = 8'h64;
  localparam logic [7:0] PRESET_PCT = 8'h0a;
  localparam logic [7:0] HW_MAX_PCT = 8'h1e;
  // Hardware ceiling wins over the preset only when the preset exceeds it
  localparam logic [7:0] EFF_PCT    = (PRESET_PCT > HW_MAX_PCT) ? HW_MAX_PCT : PRESET_PCT;
  localparam logic [7:0] OFF_PCT    = PCT_FULL - EFF_PCT;

  // ==========================================================================
  // Reset values and counter steps
  // ==========================================================================
  localparam logic [DUR_W-1:0]  DUR_ZERO  = 32'h0;
  localparam logic [DUR_W-1:0]  DUR_ONE   = 32'h1;
  localparam logic [IDLE_W-1:0] IDLE_ZERO = 40'h0;
  localparam logic [IDLE_W-1:0] IDLE_ONE  = 40'h1;
  localparam logic [FIFO_AW:0]  PTR_ZERO  = 4'h0;
  localparam logic [FIFO_AW:0]  PTR_ONE   = 4'h1;
  localparam logic [FIFO_AW:0]  FIFO_FULL = 4'h8;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h0;

  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_TXN   = 2'b01,
    ST_CALC  = 2'b11,
    ST_HOLD  = 2'b10
  } tdcl_state_type;

endpackage : tdcl_pkg

// ===== core/tdcl_calc_if.sv
interface tdcl_calc_if;
  logic                       start;
  logic [tdcl_pkg::DUR_W-1:0]  dur;
  logic                       done;
  logic [tdcl_pkg::IDLE_W-1:0] idle;

  modport calc (input start, input dur, output done, output idle);
  modport ctrl (output start, output dur, input done, input idle);
endinterface : tdcl_calc_if

// ===== core/tdcl_idle_calc.sv
module tdcl_idle_calc (
  input  wire logic   clock,
  input  wire logic   reset_n,
  tdcl_calc_if.calc   cif
);

  localparam logic [tdcl_pkg::IDLE_W-1:0] OFF_W = tdcl_pkg::IDLE_W'(tdcl_pkg::OFF_PCT);
  localparam logic [tdcl_pkg::IDLE_W-1:0] ON_W  = tdcl_pkg::IDLE_W'(tdcl_pkg::EFF_PCT);

  logic [tdcl_pkg::IDLE_W-1:0] idle_reg;
  logic [tdcl_pkg::IDLE_W-1:0] idle_next;
  logic                        done_reg;
  logic                        done_next;

  // ==========================================================================
  // Idle time, rounded up so the average never creeps over the limit
  // ==========================================================================
  always_comb begin
    done_next = cif.start;
    idle_next = idle_reg;
    if (cif.start) begin
      idle_next = (tdcl_pkg::IDLE_W'(cif.dur) * OFF_W + ON_W - tdcl_pkg::IDLE_ONE) / ON_W;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idle_reg <= tdcl_pkg::IDLE_ZERO;
      done_reg <= 1'b0;
    end else begin
      idle_reg <= idle_next;
      done_reg <= done_next;
    end
  end

  assign cif.done = done_reg;
  assign cif.idle = idle_reg;

  a_idle_ratio_exact: assert property (@(posedge clock) disable iff (!reset_n)
    cif.start |=> (cif.idle * ON_W >= tdcl_pkg::IDLE_W'($past(cif.dur)) * OFF_W)
                  && (cif.idle * ON_W < tdcl_pkg::IDLE_W'($past(cif.dur)) * OFF_W + ON_W))
    else $error("idle time does not match duty factor");

  a_hw_cap_held: assert property (@(posedge clock) disable iff (!reset_n)
    cif.start |=> (cif.idle * tdcl_pkg::IDLE_W'(tdcl_pkg::HW_MAX_PCT)
                   >= tdcl_pkg::IDLE_W'($past(cif.dur))
                      * tdcl_pkg::IDLE_W'(tdcl_pkg::PCT_FULL - tdcl_pkg::HW_MAX_PCT)))
    else $error("idle time allows duty above hardware ceiling");

endmodule : tdcl_idle_calc

// ===== core/tdcl_top.sv
module tdcl_top (
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire logic                        txn_req,
  input  wire logic                        txn_end,
  input  wire logic                        tx_active,
  input  wire logic                        user_valid,
  input  wire logic [tdcl_pkg::DATA_W-1:0] user_data,
  output logic                             user_ready,
  output logic                             tx_permit,
  output logic                             tx_blocked,
  output logic                             tx_valid,
  output logic [tdcl_pkg::DATA_W-1:0]      tx_data,
  input  wire logic                        tx_take,
  output logic [tdcl_pkg::DUR_W-1:0]       last_duration
);

  tdcl_pkg::tdcl_state_type state_reg;
  tdcl_pkg::tdcl_state_type state_next;

  logic [tdcl_pkg::DUR_W-1:0]  dur_reg;
  logic [tdcl_pkg::DUR_W-1:0]  dur_next;
  logic [tdcl_pkg::DUR_W-1:0]  last_reg;
  logic [tdcl_pkg::DUR_W-1:0]  last_next;
  logic [tdcl_pkg::IDLE_W-1:0] hold_reg;
  logic [tdcl_pkg::IDLE_W-1:0] hold_next;
  logic                        permit_reg;
  logic                        permit_next;
  logic                        blocked_reg;
  logic                        blocked_next;

  logic [tdcl_pkg::DATA_W-1:0] mem [tdcl_pkg::FIFO_DEPTH];
  logic [tdcl_pkg::FIFO_AW:0]  wr_reg;
  logic [tdcl_pkg::FIFO_AW:0]  wr_next;
  logic [tdcl_pkg::FIFO_AW:0]  rd_reg;
  logic [tdcl_pkg::FIFO_AW:0]  rd_next;
  logic [tdcl_pkg::FIFO_AW:0]  cnt_next;
  logic                        uready_reg;
  logic                        uready_next;
  logic                        txv_reg;
  logic                        txv_next;
  logic [tdcl_pkg::DATA_W-1:0] txd_reg;
  logic [tdcl_pkg::DATA_W-1:0] txd_next;
  logic                        push;
  logic                        pop;

  tdcl_calc_if cif ();

  tdcl_idle_calc u_calc (
    .clock   (clock),
    .reset_n (reset_n),
    .cif     (cif)
  );

  // ==========================================================================
  // Transaction sequencer
  // ==========================================================================
  // No port reaches the preset: the limit is a package constant only.
  assign cif.start = (state_reg == tdcl_pkg::ST_CALC) && !cif.done;
  assign cif.dur   = dur_reg;

  always_comb begin
    state_next = state_reg;
    dur_next   = dur_reg;
    last_next  = last_reg;
    hold_next  = hold_reg;
    unique case (state_reg)
      tdcl_pkg::ST_READY: begin
        if (txn_req) begin
          state_next = tdcl_pkg::ST_TXN;
          dur_next   = tdcl_pkg::DUR_ZERO;
        end
      end
      tdcl_pkg::ST_TXN: begin
        // Whole transaction stays granted until its own end marker
        if (tx_active) begin
          dur_next = dur_reg + tdcl_pkg::DUR_ONE;
        end
        if (txn_end) begin
          state_next = tdcl_pkg::ST_CALC;
          last_next  = tx_active ? dur_reg + tdcl_pkg::DUR_ONE : dur_reg;
        end
      end
      tdcl_pkg::ST_CALC: begin
        if (cif.done) begin
          state_next = tdcl_pkg::ST_HOLD;
          hold_next  = cif.idle;
        end
      end
      tdcl_pkg::ST_HOLD: begin
        if (hold_reg == tdcl_pkg::IDLE_ZERO) begin
          state_next = tdcl_pkg::ST_READY;
        end else begin
          hold_next = hold_reg - tdcl_pkg::IDLE_ONE;
        end
      end
    endcase
    permit_next  = (state_next == tdcl_pkg::ST_TXN);
    blocked_next = (state_next != tdcl_pkg::ST_READY);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg   <= tdcl_pkg::ST_READY;
      dur_reg     <= tdcl_pkg::DUR_ZERO;
      last_reg    <= tdcl_pkg::DUR_ZERO;
      hold_reg    <= tdcl_pkg::IDLE_ZERO;
      permit_reg  <= 1'b0;
      blocked_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      dur_reg     <= dur_next;
      last_reg    <= last_next;
      hold_reg    <= hold_next;
      permit_reg  <= permit_next;
      blocked_reg <= blocked_next;
    end
  end

  // ==========================================================================
  // Pending user data
  // ==========================================================================
  // Words only leave while a transaction is granted; otherwise they wait
  assign push = user_valid && uready_reg;
  assign pop  = txv_reg && tx_take;

  always_comb begin
    wr_next     = push ? wr_reg + tdcl_pkg::PTR_ONE : wr_reg;
    rd_next     = pop ? rd_reg + tdcl_pkg::PTR_ONE : rd_reg;
    cnt_next    = wr_next - rd_next;
    uready_next = (cnt_next != tdcl_pkg::FIFO_FULL);
    txv_next    = (state_next == tdcl_pkg::ST_TXN) && (cnt_next != tdcl_pkg::PTR_ZERO);
    // Bypass: the word written this edge is not yet in the array
    if (push && (wr_reg[tdcl_pkg::FIFO_AW-1:0] == rd_next[tdcl_pkg::FIFO_AW-1:0])) begin
      txd_next = user_data;
    end else begin
      txd_next = mem[rd_next[tdcl_pkg::FIFO_AW-1:0]];
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_reg[tdcl_pkg::FIFO_AW-1:0]] <= user_data;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_reg     <= tdcl_pkg::PTR_ZERO;
      rd_reg     <= tdcl_pkg::PTR_ZERO;
      uready_reg <= 1'b0;
      txv_reg    <= 1'b0;
      txd_reg    <= tdcl_pkg::DATA_ZERO;
    end else begin
      wr_reg     <= wr_next;
      rd_reg     <= rd_next;
      uready_reg <= uready_next;
      txv_reg    <= txv_next;
      txd_reg    <= txd_next;
    end
  end

  assign user_ready    = uready_reg;
  assign tx_permit     = permit_reg;
  assign tx_blocked    = blocked_reg;
  assign tx_valid      = txv_reg;
  assign tx_data       = txd_reg;
  assign last_duration = last_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_dur_counts_active: assert property (
    (state_reg == tdcl_pkg::ST_TXN && !txn_end && tx_active)
      |=> dur_reg == $past(dur_reg) + tdcl_pkg::DUR_ONE)
    else $error("transmit time not counted");

  a_last_dur_stored: assert property (
    (state_reg == tdcl_pkg::ST_TXN && txn_end && !tx_active) |=> last_reg == $past(dur_reg))
    else $error("duration not stored at transaction end");

  a_hold_blocks_start: assert property (
    (state_reg == tdcl_pkg::ST_HOLD && hold_reg != tdcl_pkg::IDLE_ZERO)
      |=> !tx_permit && tx_blocked)
    else $error("transaction granted during idle interval");

  a_hold_loads_idle: assert property (
    (state_reg == tdcl_pkg::ST_CALC && cif.done)
      |=> state_reg == tdcl_pkg::ST_HOLD && hold_reg == $past(cif.idle))
    else $error("idle interval not loaded");

  a_no_release_blocked: assert property (
    tx_valid |-> state_reg == tdcl_pkg::ST_TXN)
    else $error("data released while blocked");

  a_buffer_keeps_data: assert property (
    (push && !pop) |=> (wr_reg - rd_reg) == $past(wr_reg - rd_reg) + tdcl_pkg::PTR_ONE)
    else $error("buffered word lost");

  a_txn_not_cut: assert property (
    (state_reg == tdcl_pkg::ST_TXN && !txn_end) |=> tx_permit ##0 state_reg == tdcl_pkg::ST_TXN)
    else $error("transaction cut before its end");

  a_ready_grants_now: assert property (
    (state_reg == tdcl_pkg::ST_READY && txn_req) |=> tx_permit && !$past(tx_blocked))
    else $error("ready request not granted at once");

endmodule : tdcl_top

// ===== verif/tdcl_partner.sv
// ==========================================================================
// Scheduler and transmitter model
// ==========================================================================
module tdcl_partner (
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [7:0] len,
  input  wire logic       slow,
  input  wire logic       tx_permit,
  output logic            txn_req,
  output logic            tx_active,
  output logic            txn_end,
  output logic            tx_take
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    txn_req   = 1'b0;
    tx_active = 1'b0;
    txn_end   = 1'b0;
    tx_take   = 1'b0;
  end

  // Slow transmitter takes a word only every other cycle
  always @(negedge clock) begin
    tx_take <= slow ? ~tx_take : 1'b1;
  end

  always @(posedge clock) begin
    if (go) begin
      @(negedge clock);
      txn_req = 1'b1;
      // Request held until granted, bounded
      for (int k = 0; k < 500 && tx_permit !== 1'b1; k++) @(negedge clock);
      txn_req = 1'b0;
      // Keyed in pulses with gaps, so counting must skip the gaps
      for (int i = 0; i < int'(len); i++) begin
        tx_active = (i % 2 == 0);
        txn_end   = (i == int'(len) - 1);
        @(negedge clock);
      end
      tx_active = 1'b0;
      txn_end   = 1'b0;
    end
  end
endmodule : tdcl_partner

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIM_PCT = 10;
  localparam int CAP_PCT = 30;
  logic        clock, reset_n, go, slow, user_valid, user_ready;
  logic        tx_permit, tx_blocked, tx_valid, txn_req, txn_end, tx_active, tx_take;
  logic [7:0]  len, user_data, tx_data;
  logic [31:0] last_duration;
  logic [7:0]  got[$];
  int          fails, n_tests, g, t_fin;
  int          cyc = 0;

  tdcl_top dut (.clock(clock), .reset_n(reset_n), .txn_req(txn_req), .txn_end(txn_end),
    .tx_active(tx_active), .user_valid(user_valid), .user_data(user_data),
    .user_ready(user_ready), .tx_permit(tx_permit), .tx_blocked(tx_blocked),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take),
    .last_duration(last_duration));
  tdcl_partner mdl (.clock(clock), .go(go), .len(len), .slow(slow), .tx_permit(tx_permit),
    .txn_req(txn_req), .tx_active(tx_active), .txn_end(txn_end), .tx_take(tx_take));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_take === 1'b1) got.push_back(tx_data);
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
  end

  task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic timeout();
    fails++;
    $display("unexpected wait: expected done seen timeout");
    end_of_test();
  endtask : timeout

  function automatic int pulses(input int n);
    int c = 0;
    for (int i = 0; i < n; i++) if (i % 2 == 0) c++;
    return c;
  endfunction : pulses

  // Hardware cap wins over the preset only when the preset exceeds it
  function automatic int idle_of(input int d);
    int p = (LIM_PCT > CAP_PCT) ? CAP_PCT : LIM_PCT;
    return d * (100 - p) / p;
  endfunction : idle_of

  task automatic push(input logic [7:0] base, input int n);
    user_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      user_data = base + 8'(i);
      // Ready is judged settled, before the edge that takes the word
      for (int k = 0; k <= 100 && user_ready !== 1'b1; k++) begin
        @(negedge clock);
        if (k == 100) timeout();
      end
      @(negedge clock);
    end
    user_valid = 1'b0;
  endtask : push

  task automatic start(input int n, input logic s);
    len  = 8'(n);
    slow = s;
    go   = 1'b1;
    @(negedge clock);
    go = 1'b0;
  endtask : start

  task automatic finish(input int n);
    int k;
    k = 0;
    #1;
    while (txn_end !== 1'b1) begin
      @(negedge clock);
      #1;
      k++;
      if (k > 300) timeout();
    end
    check("permit at end", tx_permit, 1);
    @(negedge clock);
    check("permit dropped", tx_permit, 0);
    check("duration", last_duration, 40'(pulses(n)));
    t_fin = cyc;
  endtask : finish

  task automatic wait_free(input int n);
    g = 0;
    while (tx_blocked === 1'b1) begin
      g++;
      @(negedge clock);
      if (g > 3000) timeout();
    end
    // Measured from the end of the transaction, not from this call
    g = cyc - t_fin;
    check("idle held", g >= idle_of(pulses(n)), 1);
    check("idle bound", g <= idle_of(pulses(n)) + 6, 1);
  endtask : wait_free

  task automatic check_got(input logic [7:0] base, input int n);
    check("words", 40'(got.size()), 40'(n));
    foreach (got[i]) check("word", got[i], base + 8'(i));
    got.delete();
  endtask : check_got

  task automatic t_order();
    push(8'h10, 3);
    repeat (3) @(negedge clock);
    check("valid while idle", tx_valid, 0);
    got.delete();
    start(7, 1'b0);
    finish(7);
    wait_free(7);
    check_got(8'h10, 3);
    $display("test order done");
  endtask : t_order

  task automatic t_refuse();
    start(4, 1'b0);
    finish(4);
    // Second request raised at once and kept high while blocked
    start(3, 1'b0);
    wait_free(4);
    for (int k = 0; tx_permit !== 1'b1; k++) begin
      @(negedge clock);
      if (k == 3) timeout();
    end
    finish(3);
    wait_free(3);
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_full();
    start(2, 1'b0);
    finish(2);
    push(8'h40, 8);
    check("ready full", user_ready, 0);
    user_valid = 1'b1;
    user_data  = 8'h99;
    repeat (3) @(negedge clock);
    user_valid = 1'b0;
    check("valid blocked", tx_valid, 0);
    wait_free(2);
    got.delete();
    start(24, 1'b1);
    finish(24);
    check_got(8'h40, 8);
    wait_free(24);
    $display("test full done");
  endtask : t_full

  initial begin
    reset_n    = 1'b0;
    go         = 1'b0;
    slow       = 1'b0;
    len        = 8'h0;
    user_valid = 1'b0;
    user_data  = 8'h0;
    fails      = 0;
    n_tests    = 0;
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    @(negedge clock);
    check("ready", user_ready, 1);
    check("blocked", tx_blocked, 0);
    $display("test reset done");
    t_order();
    t_refuse();
    t_full();
    end_of_test();
  end
endmodule : tb
